/* File: pkg/sadc_pkg.sv */
`default_nettype none
package sadc_pkg;
    localparam int RES_W = 16;
    localparam int CLK_PERIOD_NS = 4;
    // Conversion timing, internal oscillator
    localparam int CONV_MAX_NS = 1500;
    localparam int CONV_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
    localparam int CONV_CW = $clog2(CONV_CYC + 1);
    localparam int ACQ_START_NS = 527;
    localparam int ACQ_START_CYC = (ACQ_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Supply reset recovery
    localparam int POR_WAIT_NS = 20000;
    localparam int POR_WAIT_CYC = (POR_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Start pulse: extra edges only inside this span
    localparam int CNV_EDGE_NS = 40;
    localparam int CNV_HIGH_CYC = CNV_EDGE_NS / CLK_PERIOD_NS;
    // Dip and re-rise of the start pin inside that span
    localparam int CNV_DIP_CYC = 2;
    localparam int CNV_REDO_CYC = 5;
    // Shift clock: 250 MHz / 6 = 41.7 MHz
    localparam int SCK_HALF_CYC = 3;
    localparam int SETTLE_CYC = 8;
    // Gain compression: code = in * 5 / 4, saturated
    localparam int CMP_MUL = 5;
    localparam int CMP_SHIFT = 2;
    localparam logic signed [15:0] CODE_MAX = 16'sh7fff;
    localparam logic signed [15:0] CODE_MIN = -16'sh7fff - 16'sh0001;
    localparam logic [15:0] RESULT_RST = 16'h0000;
    // Pin sampler idle levels: supply, compress off, read select high
    localparam logic [4:0] PIN_IDLE = 5'h1c;
endpackage : sadc_pkg
`default_nettype wire

/* File: pkg/sadc_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sadc_link_if;
    logic conversion_start_input;
    logic sck;
    logic readSel;
    logic busy;
    logic sdo;
    logic sdoOe;
    logic sdoWire;
    // Released output reads low; no keeper modelled
    assign sdoWire = sdoOe & sdo;
    modport dev (
        input conversion_start_input,
        input sck,
        input readSel,
        output busy,
        output sdo,
        output sdoOe
    );
    modport hst (
        output conversion_start_input,
        output sck,
        output readSel,
        input busy,
        input sdoWire
    );
endinterface : sadc_link_if
`default_nettype wire

/* File: src/sadc_adc_dev.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Compression pin low scales code range
// - Reset on supply drop, then reinitialise
// - Host waits 20us after supply reset
// - Start rising edge powers up, converts
// - Start edges ignored during conversion
// - Busy high exactly while converting
// - Host moves start only near start
// - Power down and acquire after conversion
// - Acquisition begins 527ns after start
// - Conversion ends within 1.5us
// - Last result readable while powered down
// - Host disables output, stops clock idle
// - Shift only when enabled and clocked
// - Host reads after conversion completes
// - Output changes on shift clock rise
// - Result MSB held until first rise
// - Result is two's complement
// - MSB of new result at busy fall
// - Read select high releases output
module sadc_adc_dev #(
    parameter int PorInitCyc = sadc_pkg::POR_WAIT_CYC
) (
    input wire logic ref_clk,
    input wire logic nrst,
    sadc_link_if.dev link,
    input wire logic supplyOk,
    input wire logic gainCompressN,
    input wire logic signed [15:0] sampleIn,
    output logic poweredUp,
    output logic acquiring,
    output logic initDone,
    output logic [15:0] lastResult
);
    localparam int INIT_CW = $clog2(PorInitCyc + 1);
    localparam int PIN_N = 5;
    localparam int P_CNV = 0;
    localparam int P_SCK = 1;
    localparam int P_RDL = 2;
    localparam int P_CMP = 3;
    localparam int P_SUP = 4;

    typedef enum logic [1:0] {ST_INIT, ST_DOWN, ST_CONV} sadc_state_t;

    logic [PIN_N-1:0] pinS1_q;
    logic [PIN_N-1:0] pinS1_d;
    logic [PIN_N-1:0] pinS2_q;
    logic [PIN_N-1:0] pinS2_d;
    logic [PIN_N-1:0] pinS3_q;
    logic [PIN_N-1:0] pinS3_d;

    sadc_state_t state_q;
    sadc_state_t state_d;
    logic [sadc_pkg::CONV_CW-1:0] convCnt_q;
    logic [sadc_pkg::CONV_CW-1:0] convCnt_d;
    logic [INIT_CW-1:0] initCnt_q;
    logic [INIT_CW-1:0] initCnt_d;
    logic signed [15:0] sampleHold_q;
    logic signed [15:0] sampleHold_d;
    logic compressHold_q;
    logic compressHold_d;
    logic [15:0] shift_q;
    logic [15:0] shift_d;
    logic [15:0] result_q;
    logic [15:0] result_d;
    logic busy_q;
    logic busy_d;
    logic sdoOe_q;
    logic sdoOe_d;

    logic cnvRise;
    logic sckRise;
    logic outEnabled;
    logic supplyGood;
    logic [15:0] codeOut;

    function automatic logic [15:0] scaleCode(input logic signed [15:0] raw, input logic compress);
        logic signed [18:0] wide;
        wide = 19'(19'(raw) * 19'(sadc_pkg::CMP_MUL)) >>> sadc_pkg::CMP_SHIFT;
        if (!compress)
        begin
            scaleCode = raw;
        end
        else if (wide > 19'(sadc_pkg::CODE_MAX))
        begin
            scaleCode = sadc_pkg::CODE_MAX;
        end
        else if (wide < 19'(sadc_pkg::CODE_MIN))
        begin
            scaleCode = sadc_pkg::CODE_MIN;
        end
        else
        begin
            scaleCode = wide[15:0];
        end
    endfunction : scaleCode

    // Every pin crosses two flops; third stage only for edge finding
    always_comb
    begin
        pinS1_d = {supplyOk, gainCompressN, link.readSel, link.sck, link.conversion_start_input};
        pinS2_d = pinS1_q;
        pinS3_d = pinS2_q;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            // Idle levels, so no false edge or output enable follows reset
            pinS1_q <= sadc_pkg::PIN_IDLE;
            pinS2_q <= sadc_pkg::PIN_IDLE;
            pinS3_q <= sadc_pkg::PIN_IDLE;
        end
        else
        begin
            pinS1_q <= pinS1_d;
            pinS2_q <= pinS2_d;
            pinS3_q <= pinS3_d;
        end
    end

    assign cnvRise = pinS2_q[P_CNV] & ~pinS3_q[P_CNV];
    assign sckRise = pinS2_q[P_SCK] & ~pinS3_q[P_SCK];
    assign outEnabled = ~pinS2_q[P_RDL];
    assign supplyGood = pinS2_q[P_SUP];
    assign codeOut = scaleCode(sampleHold_q, compressHold_q);

    always_comb
    begin
        state_d = state_q;
        convCnt_d = convCnt_q;
        initCnt_d = initCnt_q;
        sampleHold_d = sampleHold_q;
        compressHold_d = compressHold_q;
        shift_d = shift_q;
        result_d = result_q;
        busy_d = busy_q;
        sdoOe_d = outEnabled;
        if (sckRise && outEnabled)
        begin
            shift_d = {shift_q[14:0], 1'b0};
        end
        if (!supplyGood)
        begin
            // Supply drop: clear busy, shift register and result, restart the init period
            state_d = ST_INIT;
            initCnt_d = '0;
            busy_d = 1'b0;
            shift_d = sadc_pkg::RESULT_RST;
            result_d = sadc_pkg::RESULT_RST;
        end
        else
        begin
            unique case (state_q)
                ST_INIT:
                begin
                    // Start edges during reinit are dropped
                    if (initCnt_q == INIT_CW'(PorInitCyc - 1))
                    begin
                        state_d = ST_DOWN;
                    end
                    else
                    begin
                        initCnt_d = initCnt_q + 1'b1;
                    end
                end
                ST_DOWN:
                begin
                    // Shifting of the held result carries on here
                    if (cnvRise)
                    begin
                        state_d = ST_CONV;
                        convCnt_d = '0;
                        busy_d = 1'b1;
                        sampleHold_d = sampleIn;
                        compressHold_d = ~pinS2_q[P_CMP];
                    end
                end
                ST_CONV:
                begin
                    // No cnvRise check: the start pin is ignored here
                    if (convCnt_q == sadc_pkg::CONV_CW'(sadc_pkg::CONV_CYC - 1))
                    begin
                        state_d = ST_DOWN;
                        busy_d = 1'b0;
                        result_d = codeOut;
                        // Load wins over a shift in the same cycle
                        shift_d = codeOut;
                    end
                    else
                    begin
                        convCnt_d = convCnt_q + 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            state_q <= ST_INIT;
            convCnt_q <= '0;
            initCnt_q <= '0;
            sampleHold_q <= '0;
            compressHold_q <= 1'b0;
            shift_q <= sadc_pkg::RESULT_RST;
            result_q <= sadc_pkg::RESULT_RST;
            busy_q <= 1'b0;
            sdoOe_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            convCnt_q <= convCnt_d;
            initCnt_q <= initCnt_d;
            sampleHold_q <= sampleHold_d;
            compressHold_q <= compressHold_d;
            shift_q <= shift_d;
            result_q <= result_d;
            busy_q <= busy_d;
            sdoOe_q <= sdoOe_d;
        end
    end

    assign link.busy = busy_q;
    assign link.sdo = shift_q[15];
    assign link.sdoOe = sdoOe_q;
    assign poweredUp = (state_q == ST_CONV);
    // Sampling switch closes again partway through conversion
    assign acquiring = (state_q == ST_DOWN)
        || ((state_q == ST_CONV) && (convCnt_q >= sadc_pkg::CONV_CW'(sadc_pkg::ACQ_START_CYC)));
    assign initDone = (state_q != ST_INIT);
    assign lastResult = result_q;
endmodule : sadc_adc_dev
`default_nettype wire

/* File: src/sadc_host_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
module sadc_host_ctl #(
    parameter int PorWaitCyc = sadc_pkg::POR_WAIT_CYC
) (
    input wire logic ref_clk,
    input wire logic nrst,
    sadc_link_if.hst link,
    input wire logic supplyEvent,
    input wire logic startReq,
    output logic hostReady,
    output logic [15:0] dataOut,
    output logic dataValid
);
    localparam int WAIT_CW = $clog2(PorWaitCyc + 1);

    typedef enum logic [2:0] {H_WAIT, H_IDLE, H_CNV, H_BUSYHI, H_BUSYLO, H_SETTLE, H_SHIFT, H_END} sadc_hstate_t;

    logic [2:0] inS1_q;
    logic [2:0] inS2_q;
    sadc_hstate_t state_q;
    sadc_hstate_t state_d;
    logic [WAIT_CW-1:0] cnt_q;
    logic [WAIT_CW-1:0] cnt_d;
    logic [4:0] bitCnt_q;
    logic [4:0] bitCnt_d;
    logic sck_q;
    logic sck_d;
    logic cnv_q;
    logic cnv_d;
    logic readSel_q;
    logic readSel_d;
    logic [15:0] data_q;
    logic [15:0] data_d;
    logic valid_q;
    logic valid_d;
    logic busyS;
    logic sdoS;
    logic supS;

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            inS1_q <= '0;
            inS2_q <= '0;
        end
        else
        begin
            inS1_q <= {supplyEvent, link.sdoWire, link.busy};
            inS2_q <= inS1_q;
        end
    end

    assign busyS = inS2_q[0];
    assign sdoS = inS2_q[1];
    assign supS = inS2_q[2];

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        bitCnt_d = bitCnt_q;
        sck_d = sck_q;
        cnv_d = cnv_q;
        readSel_d = readSel_q;
        data_d = data_q;
        valid_d = 1'b0;
        if (supS)
        begin
            // Supply event restarts the full quiet period
            state_d = H_WAIT;
            cnt_d = '0;
            cnv_d = 1'b0;
            sck_d = 1'b0;
            readSel_d = 1'b1;
        end
        else
        begin
            unique case (state_q)
                H_WAIT:
                begin
                    if (cnt_q == WAIT_CW'(PorWaitCyc - 1))
                    begin
                        state_d = H_IDLE;
                    end
                    else
                    begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
                H_IDLE:
                begin
                    if (startReq)
                    begin
                        state_d = H_CNV;
                        cnv_d = 1'b1;
                        cnt_d = '0;
                    end
                end
                H_CNV:
                begin
                    // Falling edge lands inside the tolerated span
                    if (cnt_q == WAIT_CW'(sadc_pkg::CNV_HIGH_CYC - 1))
                    begin
                        cnv_d = 1'b0;
                        state_d = H_BUSYHI;
                    end
                    else if (cnt_q == WAIT_CW'(sadc_pkg::CNV_DIP_CYC))
                    begin
                        // Extra start edge inside the span; the device must ignore it
                        cnv_d = 1'b0;
                        cnt_d = cnt_q + 1'b1;
                    end
                    else if (cnt_q == WAIT_CW'(sadc_pkg::CNV_REDO_CYC))
                    begin
                        cnv_d = 1'b1;
                        cnt_d = cnt_q + 1'b1;
                    end
                    else
                    begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
                H_BUSYHI:
                begin
                    if (busyS)
                    begin
                        state_d = H_BUSYLO;
                    end
                end
                H_BUSYLO:
                begin
                    if (!busyS)
                    begin
                        state_d = H_SETTLE;
                        readSel_d = 1'b0;
                        cnt_d = '0;
                    end
                end
                H_SETTLE:
                begin
                    if (cnt_q == WAIT_CW'(sadc_pkg::SETTLE_CYC - 1))
                    begin
                        state_d = H_SHIFT;
                        cnt_d = '0;
                        bitCnt_d = '0;
                    end
                    else
                    begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
                H_SHIFT:
                begin
                    if (cnt_q == WAIT_CW'(sadc_pkg::SCK_HALF_CYC - 1) || (!sck_q && cnt_q == '0 && bitCnt_q == '0))
                    begin
                        cnt_d = '0;
                        if (!sck_q)
                        begin
                            // Capture at own rise: bit settled since last rise
                            sck_d = 1'b1;
                            data_d = {data_q[14:0], sdoS};
                            bitCnt_d = bitCnt_q + 1'b1;
                        end
                        else
                        begin
                            sck_d = 1'b0;
                            if (bitCnt_q == 5'h10)
                            begin
                                state_d = H_END;
                            end
                        end
                    end
                    else
                    begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
                H_END:
                begin
                    readSel_d = 1'b1;
                    valid_d = 1'b1;
                    state_d = H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            state_q <= H_WAIT;
            cnt_q <= '0;
            bitCnt_q <= '0;
            sck_q <= 1'b0;
            cnv_q <= 1'b0;
            readSel_q <= 1'b1;
            data_q <= sadc_pkg::RESULT_RST;
            valid_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            bitCnt_q <= bitCnt_d;
            sck_q <= sck_d;
            cnv_q <= cnv_d;
            readSel_q <= readSel_d;
            data_q <= data_d;
            valid_q <= valid_d;
        end
    end

    assign link.conversion_start_input = cnv_q;
    assign link.sck = sck_q;
    assign link.readSel = readSel_q;
    assign hostReady = (state_q == H_IDLE);
    assign dataOut = data_q;
    assign dataValid = valid_q;
endmodule : sadc_host_ctl
`default_nettype wire

/* File: dv/sadc_link_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module sadc_link_assertions (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic conversion_start_input,
    input wire logic sck,
    input wire logic readSel,
    input wire logic busy,
    input wire logic sdo,
    input wire logic sdoOe
);
    logic [9:0] busyCnt_q;
    logic [9:0] busyCnt_d;
    always_comb busyCnt_d = busy ? busyCnt_q + 10'h001 : 10'h000;
    always_ff @(posedge ref_clk) busyCnt_q <= nrst ? busyCnt_d : 10'h000;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    start_busy_a: assert property ($rose(conversion_start_input) && !busy |-> ##[2:4] $rose(busy))
        else $error("busy did not follow start edge");
    busy_len_a: assert property ($fell(busy) |-> busyCnt_q == 10'(sadc_pkg::CONV_CYC))
        else $error("conversion length wrong");
    busy_max_a: assert property (busy |-> busyCnt_q < 10'(sadc_pkg::CONV_CYC))
        else $error("conversion restarted or overran");
    // Sync latency of up to three cycles, so look back four
    sdo_hold_a: assert property ($changed(sdo) |-> $fell(busy) || $past(sck, 1) || $past(sck, 2)
        || $past(sck, 3) || $past(sck, 4))
        else $error("data bit moved without shift clock");
    sdo_gate_a: assert property ($changed(sdo) && !$fell(busy) |-> !$past(readSel, 2) || !$past(readSel, 3))
        else $error("data shifted while released");
    oe_follow_a: assert property ($past(readSel, 3) == $past(readSel, 4) |-> sdoOe == !$past(readSel, 4))
        else $error("output enable does not follow read select");
    cnv_pulse_a: assert property ($rose(conversion_start_input) |-> ##[1:10] $fell(conversion_start_input))
        else $error("start pulse too long");
    read_after_a: assert property ($rose(sck) |-> !busy)
        else $error("shift clock during conversion");
    idle_sck_a: assert property (readSel |-> !sck)
        else $error("shift clock runs while released");
    cover property ($fell(busy));
    cover property (sdoOe && $rose(sck));
    cover property ($rose(conversion_start_input));
    cover property ($rose(conversion_start_input) && busy);
endmodule : sadc_link_assertions
`default_nettype wire

/* File: dv/sar_adc_conversion_readout_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_readout_tb;
    localparam int PorInit = 40;
    localparam int PorWait = 50;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic supplyOk = 1'b1;
    logic supplyEvent = 1'b0;
    logic gainCompressN = 1'b1;
    logic startReq = 1'b0;
    logic signed [15:0] sampleIn = 16'sh0000;
    logic poweredUp, acquiring, initDone, hostReady, dataValid, busyPrev, acqPrev;
    logic [15:0] lastResult, dataOut, e;
    logic [15:0] expQ[$];
    logic [16:0] tbl[6] = '{17'h0_7fff, 17'h1_7fff, 17'h0_8000, 17'h0_6666, 17'h0_6667, 17'h0_ffff};
    int fails = 0;
    int cmp_count = 0;
    int cycles = 0;
    int acqCnt = 0;
    int t0 = 0;

    sadc_link_if link();
    sadc_adc_dev #(.PorInitCyc(PorInit)) u_sadc_adc_dev (.ref_clk(ref_clk), .nrst(nrst), .link(link),
        .supplyOk(supplyOk), .gainCompressN(gainCompressN), .sampleIn(sampleIn), .poweredUp(poweredUp),
        .acquiring(acquiring), .initDone(initDone), .lastResult(lastResult));
    sadc_host_ctl #(.PorWaitCyc(PorWait)) u_sadc_host_ctl (.ref_clk(ref_clk), .nrst(nrst), .link(link),
        .supplyEvent(supplyEvent), .startReq(startReq), .hostReady(hostReady), .dataOut(dataOut),
        .dataValid(dataValid));
    sadc_link_assertions u_sadc_link_assertions (.ref_clk(ref_clk), .nrst(nrst), .conversion_start_input(link.conversion_start_input),
        .sck(link.sck), .readSel(link.readSel), .busy(link.busy), .sdo(link.sdo), .sdoOe(link.sdoOe));

    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("fails=%0d cmp_count=%0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run

    function automatic logic [15:0] exp_code(input logic [15:0] s, input logic gcN);
        int v;
        v = (int'($signed(s)) * sadc_pkg::CMP_MUL) >>> sadc_pkg::CMP_SHIFT;
        if (gcN)
            v = int'($signed(s));
        else if (v > int'(sadc_pkg::CODE_MAX))
            v = int'(sadc_pkg::CODE_MAX);
        else if (v < int'(sadc_pkg::CODE_MIN))
            v = int'(sadc_pkg::CODE_MIN);
        return v[15:0];
    endfunction : exp_code

    task automatic wait_ready();
        @(negedge ref_clk);
        while (!hostReady)
            @(negedge ref_clk);
    endtask : wait_ready

    task automatic convert(input logic [15:0] s, input logic gcN);
        wait_ready();
        @(posedge ref_clk);
        startReq <= 1'b1;
        sampleIn <= s;
        gainCompressN <= gcN;
        expQ.push_back(exp_code(s, gcN));
        @(posedge ref_clk);
        startReq <= 1'b0;
    endtask : convert

    // A host start request during a conversion must leave no trace; outside H_IDLE the only start edge the host drives is the H_CNV re-rise
    task automatic stray_start();
        @(negedge ref_clk);
        while (!link.busy)
            @(negedge ref_clk);
        check({15'h0000, hostReady}, 16'h0000);
        @(posedge ref_clk);
        startReq <= 1'b1;
        @(posedge ref_clk);
        startReq <= 1'b0;
    endtask : stray_start

    always @(negedge ref_clk)
    begin
        cycles++;
        if (nrst && dataValid)
        begin
            if (expQ.size() == 0)
                check(dataOut, 16'hxxxx);
            else
            begin
                e = expQ.pop_front();
                check(dataOut, e);
                check(lastResult, e);
                check({acquiring, poweredUp, 14'h0000}, 16'h8000);
            end
        end
        if (link.busy && !busyPrev)
        begin
            acqCnt = 0;
            check({15'h0000, poweredUp}, 16'h0001);
        end
        else
            acqCnt++;
        if (acquiring && !acqPrev && busyPrev)
            check(16'(acqCnt), 16'(sadc_pkg::ACQ_START_CYC));
        busyPrev = link.busy;
        acqPrev = acquiring;
        if (cycles > 20000)
        begin
            fails++;
            $display("timeout at %0t", $time);
            complete_run();
        end
    end

    initial
    begin
        void'($urandom(73));
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        t0 = cycles;
        wait_ready();
        check(16'(cycles - t0 >= PorWait), 16'h0001);
        for (int i = 0; i < 6; i++)
        begin
            convert(tbl[i][15:0], tbl[i][16]);
            if (i == 2)
                stray_start();
        end
        for (int i = 0; i < 6; i++)
            convert(16'($urandom), 1'($urandom));
        while (expQ.size() != 0)
            @(negedge ref_clk);
        @(posedge ref_clk);
        supplyOk <= 1'b0;
        supplyEvent <= 1'b1;
        t0 = cycles;
        repeat (5) @(posedge ref_clk);
        supplyOk <= 1'b1;
        supplyEvent <= 1'b0;
        @(negedge ref_clk);
        check(lastResult, sadc_pkg::RESULT_RST);
        check({15'h0000, initDone}, 16'h0000);
        wait_ready();
        check(16'(cycles - t0 >= PorWait), 16'h0001);
        check({15'h0000, initDone}, 16'h0001);
        convert(16'h1234, 1'b1);
        convert(16'($urandom), 1'b0);
        while (expQ.size() != 0)
            @(negedge ref_clk);
        complete_run();
    end
endmodule : sar_adc_conversion_readout_tb
`default_nettype wire
